// ===== verilog/iesa_pkg.sv
// Package: register map, reset values and carrier types for the enable/status/abort block
package iesa_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFF_TX_ABORT_CLEAR  = 8'h54;  // Read clears abort irq and cause
  localparam logic [7:0] OFF_GENERAL_CALL_IRQ_CLEAR  = 8'h68;  // general_call_clear
  localparam logic [7:0] OFF_ENABLE          = 8'h6c;  // controller_enable
  localparam logic [7:0] OFF_STATUS          = 8'h70;  // controller_status
  localparam logic [7:0] OFF_TX_LEVEL        = 8'h74;  // transmit_fifo_level
  localparam logic [7:0] OFF_RX_LEVEL        = 8'h78;  // receive_fifo_level
  localparam logic [7:0] OFF_HOLD            = 8'h7c;  // data_hold_time
  localparam logic [7:0] OFF_ABORT_CAUSE     = 8'h80;  // transmit_abort_cause

  // Field positions in controller_enable
  localparam int ENA_ON_BIT    = 0;
  localparam int ENA_ABORT_BIT = 1;

  // Field positions in controller_status
  localparam int ST_ACTIVITY   = 0;
  localparam int ST_TX_SPACE   = 1;
  localparam int ST_TX_EMPTY   = 2;
  localparam int ST_RX_NONEMPT = 3;
  localparam int ST_RX_FULL    = 4;
  localparam int ST_MST_BUSY   = 5;
  localparam int ST_SLV_BUSY   = 6;

  // Field positions in transmit_abort_cause
  localparam int CAUSE_FLUSH_LSB = 24;
  localparam int CAUSE_FLUSH_W   = 8;
  localparam int CAUSE_BITS_W    = 17;  // Cause flags occupy bits 16..0

  // FIFO geometry seen through the level counters
  localparam int         LEVEL_W    = 4;
  localparam logic [3:0] FIFO_DEPTH = 4'h8;

  // Reset values
  localparam logic [15:0] HOLD_RESET   = 16'h0001;
  localparam logic [6:0]  STATUS_RESET = 7'h06;  // Tx empty and tx has space

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Events and state reported by the protocol engine
  typedef struct packed {
    logic                    master_fsm_busy;   // Master machine not idle
    logic                    slave_fsm_busy;    // Slave machine not idle
    logic [LEVEL_W-1:0]      tx_level_count;    // Entries in transmit FIFO
    logic [LEVEL_W-1:0]      rx_level_count;    // Entries in receive FIFO
    logic                    general_call_seen; // One-cycle general call event
    logic [CAUSE_BITS_W-1:0] abort_cause;       // One-cycle abort cause flags
    logic                    abort_done;        // One-cycle: requested abort finished
  } iesa_engine_s;

  // Controls handed to the protocol engine
  typedef struct packed {
    logic        controller_on;      // Controller enabled
    logic        abort_request;      // Transfer abort in progress
    logic [15:0] data_hold_cycles;   // SDA hold in controller clock periods
  } iesa_ctrl_s;

endpackage : iesa_pkg

// ===== verilog/iesa_ctrl_status.sv
// Enable, status, FIFO level, hold time and abort cause registers over AXI4-Lite
// What this block does
// - Reading general call clear drops general_call_irq
// - Abort bit set by write, reads busy
// - Enable bit turns controller on, resets 0
// - Status 6/5 show slave/master busy
// - Status 4 rx full, 3 rx nonempty
// - Status 2 tx empty, resets 1
// - Status 1 tx has space, resets 1
// - Transmit level reads tx entry count
// - Receive level reads rx entry count
// - Hold field sets SDA hold, resets 1
// - Abort captures tx level into 31:24
// - Bit 16 marks software-requested master abort
// - Bit 15 slave read command error
// - Bit 14 slave lost bus transmitting
// - Bit 13 stale tx data flushed
// - Bit 12 arbitration lost
// - Bit 11 master op while master disabled
// - Bits 10/9/8 no repeated start aborts
// - Bits 7/6 start byte, hs code acked
// - Bits 5/4 general call read, unanswered
// - Bit 3 data byte not acknowledged
// - Bit 2 second address byte unanswered
// - Abort clear read drops irq and cause
`timescale 1ns/100ps
module iesa_ctrl_status
  import iesa_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  // AXI4-Lite write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  // AXI4-Lite read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Protocol engine side
  input  wire iesa_engine_s engine,
  output iesa_ctrl_s        ctrl,
  output logic              general_call_irq,
  output logic              transmit_abort_irq
);

  // Write channel holding state
  logic        aw_held_reg;     // Write address captured
  logic [7:0]  aw_addr_reg;     // Captured write address
  logic        w_held_reg;      // Write data captured
  logic [31:0] w_data_reg;      // Captured write data
  logic [3:0]  w_strb_reg;      // Captured byte enables
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  // Read channel state
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  // Block registers
  logic        on_reg;          // Controller enable
  logic        abort_reg;       // Abort in progress
  logic [15:0] hold_reg;        // SDA hold cycles
  logic [6:0]  status_reg;      // Registered status bits
  logic [LEVEL_W-1:0] tx_level_reg;
  logic [LEVEL_W-1:0] rx_level_reg;
  logic [31:0] cause_reg;       // Abort cause and flush count
  logic        gen_irq_reg;     // Raw general call interrupt
  logic        abrt_irq_reg;    // Raw transmit abort interrupt
  // Decoded strobes
  logic        do_write;        // Both halves of a write present
  logic        ar_take;         // Read address accepted this edge
  logic        abort_event;     // Any abort cause fired
  logic [31:0] read_mux;        // Data for the accepted read
  logic [1:0]  read_resp;       // Response for the accepted read
  logic        sw_abort_hit;    // Software writes 1 to abort bit

  // Port drive straight from flops
  assign awready            = awready_reg;
  assign wready             = wready_reg;
  assign bvalid             = bvalid_reg;
  assign bresp              = bresp_reg;
  assign arready            = arready_reg;
  assign rvalid             = rvalid_reg;
  assign rdata              = rdata_reg;
  assign rresp              = rresp_reg;
  assign ctrl.controller_on    = on_reg;
  assign ctrl.abort_request    = abort_reg;
  assign ctrl.data_hold_cycles = hold_reg;
  assign general_call_irq   = gen_irq_reg;
  assign transmit_abort_irq = abrt_irq_reg;

  // Commit only once address and data are both held and no response is pending
  assign do_write    = aw_held_reg && w_held_reg && !bvalid_reg;
  assign ar_take     = arvalid && arready_reg;
  assign abort_event = |engine.abort_cause;
  assign sw_abort_hit = do_write && (aw_addr_reg == OFF_ENABLE) && w_strb_reg[0]
                        && w_data_reg[ENA_ABORT_BIT];

  // Write address channel: one address held until the write commits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      awready_reg <= 1'b1;
    end
    else if (awvalid && awready_reg)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= awaddr;
      awready_reg <= 1'b0;
    end
    else if (do_write)
    begin
      aw_held_reg <= 1'b0;
    end
    else if (bvalid_reg && bready)
    begin
      // Ready again only after the response is gone, one write at a time
      awready_reg <= 1'b1;
    end
  end

  // Write data channel: independent of the address, either may come first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      wready_reg <= 1'b1;
    end
    else if (wvalid && wready_reg)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
      wready_reg <= 1'b0;
    end
    else if (do_write)
    begin
      w_held_reg <= 1'b0;
    end
    else if (bvalid_reg && bready)
    begin
      wready_reg <= 1'b1;
    end
  end

  // Write response: writes to read-only words are ignored but acknowledged
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      unique case (aw_addr_reg)
        OFF_TX_ABORT_CLEAR, OFF_GENERAL_CALL_IRQ_CLEAR, OFF_ENABLE, OFF_STATUS,
        OFF_TX_LEVEL, OFF_RX_LEVEL, OFF_HOLD, OFF_ABORT_CAUSE:
          bresp_reg <= RESP_OKAY;
        default:
          bresp_reg <= RESP_SLVERR;  // Unmapped address
      endcase
    end
    else if (bvalid_reg && bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  // Enable bit, software owned
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      on_reg <= 1'b0;
    else if (do_write && (aw_addr_reg == OFF_ENABLE) && w_strb_reg[0])
      on_reg <= w_data_reg[ENA_ON_BIT];
  end

  // Abort bit: a 1 starts it, only the engine finishing ends it;
  // writing 0 cannot cancel an abort already under way
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      abort_reg <= 1'b0;
    else if (sw_abort_hit)
      abort_reg <= 1'b1;
    else if (engine.abort_done)
      abort_reg <= 1'b0;
  end

  // SDA hold time, byte lanes honoured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hold_reg <= HOLD_RESET;
    else if (do_write && (aw_addr_reg == OFF_HOLD))
    begin
      if (w_strb_reg[0])
        hold_reg[7:0] <= w_data_reg[7:0];
      if (w_strb_reg[1])
        hold_reg[15:8] <= w_data_reg[15:8];
    end
  end

  // Status and levels registered from the engine, one cycle behind it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_reg   <= STATUS_RESET;
      tx_level_reg <= '0;
      rx_level_reg <= '0;
    end
    else
    begin
      status_reg[ST_SLV_BUSY]   <= engine.slave_fsm_busy;
      status_reg[ST_MST_BUSY]   <= engine.master_fsm_busy;
      status_reg[ST_RX_FULL]    <= (engine.rx_level_count == FIFO_DEPTH);
      status_reg[ST_RX_NONEMPT] <= (engine.rx_level_count != 4'h0);
      status_reg[ST_TX_EMPTY]   <= (engine.tx_level_count == 4'h0);
      status_reg[ST_TX_SPACE]   <= (engine.tx_level_count < FIFO_DEPTH);
      status_reg[ST_ACTIVITY]   <= engine.master_fsm_busy
                                   | engine.slave_fsm_busy;
      tx_level_reg <= engine.tx_level_count;
      rx_level_reg <= engine.rx_level_count;
    end
  end

  // Abort cause: flags accumulate per bit; a new event beats a clearing read
  // in the same cycle so no cause is lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cause_reg <= 32'h0000_0000;
    else if (abort_event)
    begin
      // Engine level this edge is the level just before the flush
      cause_reg[CAUSE_FLUSH_LSB +: CAUSE_FLUSH_W] <=
        {{(CAUSE_FLUSH_W-LEVEL_W){1'b0}}, engine.tx_level_count};
      // Bit 16 sw abort, 15 slave read cmd, 14 slave bus lost, 13 stale flush,
      // 12 arbitration, 11 master disabled, 10..8 no repeated start,
      // 7..6 erroneous acks, 5..4 general call, 3 data nack, 2 second addr nack
      if (ar_take && (araddr == OFF_TX_ABORT_CLEAR))
        cause_reg[CAUSE_BITS_W-1:0] <= engine.abort_cause;
      else
        cause_reg[CAUSE_BITS_W-1:0] <= cause_reg[CAUSE_BITS_W-1:0]
                                       | engine.abort_cause;
    end
    else if (ar_take && (araddr == OFF_TX_ABORT_CLEAR))
      cause_reg <= 32'h0000_0000;
  end

  // Raw transmit abort interrupt, set wins over the clearing read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      abrt_irq_reg <= 1'b0;
    else if (abort_event)
      abrt_irq_reg <= 1'b1;
    else if (ar_take && (araddr == OFF_TX_ABORT_CLEAR))
      abrt_irq_reg <= 1'b0;
  end

  // Raw general call interrupt, set wins over the clearing read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gen_irq_reg <= 1'b0;
    else if (engine.general_call_seen)
      gen_irq_reg <= 1'b1;
    else if (ar_take && (araddr == OFF_GENERAL_CALL_IRQ_CLEAR))
      gen_irq_reg <= 1'b0;
  end

  // Read data selection from the live address
  always_comb
  begin
    read_mux  = 32'h0000_0000;
    read_resp = RESP_OKAY;
    unique case (araddr)
      OFF_TX_ABORT_CLEAR: read_mux = {31'h0, abrt_irq_reg};
      OFF_GENERAL_CALL_IRQ_CLEAR: read_mux = {31'h0, gen_irq_reg};
      OFF_ENABLE:         read_mux = {30'h0, abort_reg, on_reg};
      OFF_STATUS:         read_mux = {25'h0, status_reg};
      OFF_TX_LEVEL:       read_mux = {28'h0, tx_level_reg};
      OFF_RX_LEVEL:       read_mux = {28'h0, rx_level_reg};
      OFF_HOLD:           read_mux = {16'h0, hold_reg};
      OFF_ABORT_CAUSE:    read_mux = cause_reg;
      default:            read_resp = RESP_SLVERR;  // Unmapped reads as zero
    endcase
  end

  // Read channel: one read in flight, data one cycle after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= read_mux;
      rresp_reg   <= read_resp;
    end
    else if (rvalid_reg && rready)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

endmodule : iesa_ctrl_status

// ===== sim/iesa_engine_model.sv
// Protocol engine stand-in: levels, event pulses and abort completion
`timescale 1ns/100ps
module iesa_engine_model
  import iesa_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Scripted state and one-cycle events from the bench
  input  wire logic [1:0]  busy_set,
  input  wire logic [3:0]  tx_set,
  input  wire logic [3:0]  rx_set,
  input  wire logic        gc_fire,
  input  wire logic [16:0] cause_fire,
  input  wire logic [3:0]  done_wait,
  // Block side
  input  wire iesa_ctrl_s  ctrl,
  output iesa_engine_s     engine
);
  logic       pend_reg;  // Abort seen, countdown running
  logic       done_reg;  // Completion pulse
  logic [3:0] wait_reg;  // Cycles left before completion

  // Finish a requested abort after a scripted delay; done blocks re-arming
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_reg <= 1'b0;
      done_reg <= 1'b0;
      wait_reg <= 4'h0;
    end
    else
    begin
      done_reg <= pend_reg && wait_reg == 4'h0;
      if (ctrl.abort_request && !pend_reg && !done_reg)
      begin
        pend_reg <= 1'b1;
        wait_reg <= done_wait;
      end
      else if (pend_reg && wait_reg == 4'h0)
        pend_reg <= 1'b0;
      else if (pend_reg)
        wait_reg <= wait_reg - 4'h1;
    end
  end

  // Completion also reports the software abort cause
  assign engine = '{master_fsm_busy: busy_set[0], slave_fsm_busy: busy_set[1],
                    tx_level_count: tx_set, rx_level_count: rx_set,
                    general_call_seen: gc_fire, abort_done: done_reg,
                    abort_cause: cause_fire | {done_reg, 16'h0}};
endmodule : iesa_engine_model

// ===== sim/iesa_ctrl_status_assertions.sv
// Checker: bus timing, interrupt and control register relations
`timescale 1ns/100ps
module iesa_ctrl_status_assertions
  import iesa_pkg::*;
(
  // Clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  // Register bus
  input wire logic         awvalid,
  input wire logic         awready,
  input wire logic         wvalid,
  input wire logic         wready,
  input wire logic         bvalid,
  input wire logic         bready,
  input wire logic         arvalid,
  input wire logic         arready,
  input wire logic [7:0]   araddr,
  input wire logic         rvalid,
  input wire logic         rready,
  input wire logic [31:0]  rdata,
  // Engine link
  input wire iesa_engine_s engine,
  input wire iesa_ctrl_s   ctrl,
  input wire logic         general_call_irq,
  input wire logic         transmit_abort_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both halves of a write taken, answer comes two cycles after
  sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
  sequence s_resp; !bvalid ##1 bvalid; endsequence
  property p_write_resp; s_wr_take |=> s_resp; endproperty
  a_write_resp: assert property (p_write_resp) else $error("write answer late");
  property p_read_lat; arvalid && arready |=> rvalid && !arready; endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_gc_set; engine.general_call_seen |=> general_call_irq; endproperty
  a_gc_set: assert property (p_gc_set) else $error("general call irq missed");
  property p_gc_clear;
    arvalid && arready && araddr == OFF_GENERAL_CALL_IRQ_CLEAR && !engine.general_call_seen
      |=> !general_call_irq;
  endproperty
  a_gc_clear: assert property (p_gc_clear) else $error("general call irq kept");
  property p_ab_set; |engine.abort_cause |=> transmit_abort_irq; endproperty
  a_ab_set: assert property (p_ab_set) else $error("abort irq missed");
  property p_ab_clear;
    arvalid && arready && araddr == OFF_TX_ABORT_CLEAR && !(|engine.abort_cause)
      |=> !transmit_abort_irq;
  endproperty
  a_ab_clear: assert property (p_ab_clear) else $error("abort irq kept");
  property p_abort_hold; ctrl.abort_request && !engine.abort_done |=> ctrl.abort_request;
  endproperty
  a_abort_hold: assert property (p_abort_hold) else $error("abort bit lost");
  property p_abort_rise; $rose(ctrl.abort_request) |-> $rose(bvalid); endproperty
  a_abort_rise: assert property (p_abort_rise) else $error("abort without write");
  property p_hold_write; $changed(ctrl.data_hold_cycles) |-> $rose(bvalid); endproperty
  a_hold_write: assert property (p_hold_write) else $error("hold changed alone");
  property p_reset;
    disable iff (1'b0) !aresetn |=> !ctrl.controller_on && ctrl.data_hold_cycles == HOLD_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("control reset wrong");
endmodule : iesa_ctrl_status_assertions

bind iesa_ctrl_status iesa_ctrl_status_assertions iesa_ctrl_status_assertions_i (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
  .arready, .araddr, .rvalid, .rready, .rdata, .engine, .ctrl, .general_call_irq,
  .transmit_abort_irq);

// ===== sim/test_iesa_ctrl_status.sv
// Testbench: register traffic against the scripted engine
`timescale 1ns/100ps
module test_iesa_ctrl_status
  import iesa_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, gc_fire = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, busy_set = 2'h0;
  logic [3:0]  tx_set = 4'h0, rx_set = 4'h0, done_wait = 4'h0;
  logic [16:0] cause_fire = 17'h0;
  logic awready, wready, bvalid, arready, rvalid, general_call_irq, transmit_abort_irq;
  iesa_engine_s engine;
  iesa_ctrl_s   ctrl;
  int n_errors = 0, samples_checked = 0;

  iesa_ctrl_status iesa_ctrl_status_i (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .engine, .ctrl, .general_call_irq, .transmit_abort_irq);
  iesa_engine_model iesa_engine_model_i (.aclk, .aresetn, .busy_set, .tx_set, .rx_set,
    .gc_fire, .cause_fire, .done_wait, .ctrl, .engine);

  // 50 ns clock
  initial
  begin
    forever #25 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken; response checked
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY, input logic [3:0] st = 4'hf);
    logic aw_on, w_on;
    aw_on = 1'b1;
    w_on = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_on || w_on)
    begin
      @(posedge aclk);
      if (aw_on && awready)
      begin
        aw_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_on && wready)
      begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end
    // Raised after both halves are taken, so no step assigns it twice
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  // Read one word and compare data and response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er = RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd_chk

  task automatic t_regs;
    rd_chk(OFF_STATUS, 32'h6);
    rd_chk(OFF_ENABLE, 32'h0);
    rd_chk(OFF_HOLD, 32'h1);
    wr(OFF_HOLD, 32'h0000beef);
    rd_chk(OFF_HOLD, 32'hbeef);
    chk({16'h0, ctrl.data_hold_cycles}, 32'hbeef);
    wr(OFF_HOLD, 32'h00001234, RESP_OKAY, 4'h1);
    rd_chk(OFF_HOLD, 32'hbe34);
    wr(OFF_STATUS, 32'hffffffff);
    rd_chk(OFF_STATUS, 32'h6);
    wr(8'h00, 32'hffffffff, RESP_SLVERR);
    wr(OFF_ENABLE, 32'h1);
    rd_chk(OFF_ENABLE, 32'h1);
    chk({31'h0, ctrl.controller_on}, 32'h1);
    wr(OFF_ENABLE, 32'h2, RESP_OKAY, 4'he);
    rd_chk(OFF_ENABLE, 32'h1);
    rd_chk(8'h00, 32'h0, RESP_SLVERR);
    $display("test regs done");
  endtask : t_regs

  // Boundary levels: full, empty, half, with each busy mix except neither busy
  task automatic t_status;
    logic [1:0] b;
    logic [3:0] t, r;
    for (int k = 0; k < 3; k++)
    begin
      b = 2'(k + 1);
      t = 4'(k * 4);
      r = 4'(8 - k * 4);
      busy_set <= b; tx_set <= t; rx_set <= r;
      repeat (2) @(posedge aclk);
      rd_chk(OFF_STATUS, {25'h0, b, r == 8, r != 0, t == 0, t < 8, |b});
      rd_chk(OFF_TX_LEVEL, {28'h0, t});
      rd_chk(OFF_RX_LEVEL, {28'h0, r});
    end
    $display("test status done");
  endtask : t_status

  // Every cause flag alone, with the flush count beside it
  task automatic t_causes;
    for (int i = 0; i < 17; i++)
    begin
      tx_set <= 4'(i % 8); cause_fire <= 17'(1) << i;
      @(posedge aclk);
      cause_fire <= 17'h0;
      rd_chk(OFF_ABORT_CAUSE, {8'(i % 8), 7'h0, 17'(1) << i});
      chk({31'h0, transmit_abort_irq}, 32'h1);
      rd_chk(OFF_TX_ABORT_CLEAR, 32'h1);
      rd_chk(OFF_ABORT_CAUSE, 32'h0);
    end
    $display("test causes done");
  endtask : t_causes

  // Slow completion, a zero write meanwhile, then prompt completion
  task automatic t_abort;
    tx_set <= 4'h3; done_wait <= 4'hf;
    wr(OFF_ENABLE, 32'h3);
    rd_chk(OFF_ENABLE, 32'h3);
    wr(OFF_ENABLE, 32'h1);
    rd_chk(OFF_ENABLE, 32'h3);
    repeat (20) @(posedge aclk);
    rd_chk(OFF_ENABLE, 32'h1);
    rd_chk(OFF_ABORT_CAUSE, 32'h03010000);
    rd_chk(OFF_TX_ABORT_CLEAR, 32'h1);
    done_wait <= 4'h0;
    wr(OFF_ENABLE, 32'h3);
    repeat (5) @(posedge aclk);
    rd_chk(OFF_ENABLE, 32'h1);
    rd_chk(OFF_TX_ABORT_CLEAR, 32'h1);
    $display("test abort done");
  endtask : t_abort

  task automatic t_gcall;
    gc_fire <= 1'b1;
    @(posedge aclk);
    gc_fire <= 1'b0;
    @(posedge aclk);
    chk({31'h0, general_call_irq}, 32'h1);
    rd_chk(OFF_GENERAL_CALL_IRQ_CLEAR, 32'h1);
    chk({31'h0, general_call_irq}, 32'h0);
    $display("test general call done");
  endtask : t_gcall

  // Mid-run reset with enable, hold and a raised irq away from reset values
  task automatic t_reset;
    busy_set <= 2'h0;
    tx_set <= 4'h0;
    rx_set <= 4'h0;
    gc_fire <= 1'b1;
    @(posedge aclk);
    gc_fire <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk({31'h0, general_call_irq}, 32'h0);
    chk({31'h0, ctrl.controller_on}, 32'h0);
    rd_chk(OFF_ENABLE, 32'h0);
    rd_chk(OFF_HOLD, 32'h1);
    rd_chk(OFF_STATUS, 32'h6);
    rd_chk(OFF_TX_LEVEL, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // Main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_status();
    t_causes();
    t_abort();
    t_gcall();
    t_reset();
    end_sim();
  end

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    end_sim();
  end
endmodule : test_iesa_ctrl_status
